// [logic/pmp_defines.svh]
`ifndef PMP_DEFINES_SVH
`define PMP_DEFINES_SVH
// Register indices on the local register port.
`define PMP_R_CTRL 4'h0
`define PMP_R_MODE 4'h1
`define PMP_R_ADDR 4'h2
`define PMP_R_DATA 4'h3
`define PMP_R_STAT 4'h4
// Slave buffers sit at indices 8 to 11 (index bits 3:2 equal 2).
`define PMP_R_BUF 2'h2
// Control register fields (lsb positions).
`define PMP_C_ON 15
`define PMP_C_IDLE 13
`define PMP_C_MUX 11
`define PMP_C_BE 10
`define PMP_C_WR 9
`define PMP_C_RD 8
`define PMP_C_CSF 6
`define PMP_C_ALP 5
`define PMP_C_CSP 3
`define PMP_C_BEP 2
`define PMP_C_WRP 1
`define PMP_C_RDP 0
`define PMP_C_WMASK 16'hbfef
// Mode register fields (lsb positions); bit 15 is the busy flag.
`define PMP_M_IRQ 13
`define PMP_M_STEP 11
`define PMP_M_WIDE 10
`define PMP_M_MODE 8
`define PMP_M_SETUP 6
`define PMP_M_STRB 2
`define PMP_M_HOLD 0
`define PMP_M_WMASK 16'h7fff
// Address register chip select bit and status flag positions.
`define PMP_A_CS 14
`define PMP_S_OVF 14
`define PMP_S_UNF 6
`define PMP_RST 16'h0000
// Field codes.
`define PMP_MUX_SEP 2'h0
`define PMP_MUX_PART 2'h1
`define PMP_MUX_FULL 2'h2
`define PMP_CSF_CS 2'h2
`define PMP_MD_LEG 2'h0
`define PMP_MD_ADR 2'h1
`define PMP_IRQ_CYC 2'h1
`define PMP_IRQ_STALL 2'h2
`define PMP_IRQ_BUF 2'h3
`define PMP_STEP_INC 2'h1
`define PMP_STEP_DEC 2'h2
`define PMP_STEP_BUF 2'h3
// One instruction cycle and the clock period, in ns.
`define PMP_TCY_NS 4
`define PMP_CLK_NS 4
`define PMP_TCY_CLKS ((`PMP_TCY_NS + `PMP_CLK_NS - 1) / `PMP_CLK_NS)
`endif

// [logic/pmp_pkg.sv]
package pmp_pkg;
  // Master transfer phases, one-hot.
  typedef enum logic [5:0] {
    PMP_IDLE = 6'h01,
    PMP_ALO = 6'h02,
    PMP_AHI = 6'h04,
    PMP_SETUP = 6'h08,
    PMP_STRB = 6'h10,
    PMP_HOLD = 6'h20
  } pmp_xfer_e;
  // Pin levels seen from the outside.
  typedef struct packed {
    logic [7:0] pd;
    logic [1:0] pa;
    logic cs;
    logic rd;
    logic wr;
  } pmp_host_s;
  // Pin drive; every enable is low while this block drives the pin.
  typedef struct packed {
    logic [7:0] pd_out;
    logic pd_oe_n;
    logic [13:0] pa_out;
    logic pa_oe_n;
    logic cs_out;
    logic cs_oe_n;
    logic rd_out;
    logic rd_oe_n;
    logic wr_out;
    logic wr_oe_n;
    logic be_out;
    logic be_oe_n;
  } pmp_pins_s;
endpackage

// [logic/pmp_port.sv]
// What this block does
// - Port off means no off-chip access.
// - Idle halt bit freezes port in Idle.
// - Mux field places address on data pins.
// - Byte enable pin driven only when enabled.
// - Each strobe pin driven only when enabled.
// - Chip select field picks select or address.
// - Latch and select polarity bits set levels.
// - Polarity ignored on pins used as address.
// - Byte enable polarity bit sets level.
// - Write polarity covers enable in mode 1.
// - Read polarity covers direction in mode 1.
// - Busy shows a master transfer in flight.
// - Irq mode: none, per cycle, or stall.
// - Irq mode 3 flags buffer 3 accesses.
// - Step mode increments or decrements address.
// - Step mode 3 walks legacy slave buffers.
// - Wide mode makes two byte transfers.
// - Port mode picks master or slave kind.
// - Setup wait gives 1 to 4 cycles.
// - Strobe wait adds 0 to 15 cycles.
// - Hold wait gives 1 to 4 cycles.
// - Zero strobe wait drops setup and hold.
// - Select bit drives chip select level.
// - Host write to full buffer sets overflow.
// - Host read of empty buffer sets underflow.
`include "pmp_defines.svh"
module pmp_port (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic CPU_IDLE,
  output logic CPU_STALL,
  output logic PORT_IRQ,
  input wire pmp_pkg::pmp_host_s HOST_IN,
  output pmp_pkg::pmp_pins_s PIN_OUT
);
  import pmp_pkg::*;

  localparam logic [3:0] TCY_M1 = 4'(`PMP_TCY_CLKS - 1);

  // Software visible state.
  logic [15:0] ctrl_r, ctrl_nxt, mode_r, mode_nxt, addr_r, addr_nxt;
  logic [15:0] mdat_r, mdat_nxt, rdat_r, rdat_nxt;
  // Master sequencer state.
  pmp_xfer_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt, tdiv_r, tdiv_nxt;
  logic hi_r, hi_nxt, wdir_r, wdir_nxt, irq_r, irq_nxt;
  // Slave buffers and their flags.
  logic [7:0] ib_r [4];
  logic [7:0] ib_nxt [4];
  logic [7:0] ob_r [4];
  logic [7:0] ob_nxt [4];
  logic [3:0] ibf_r, ibf_nxt, obe_r, obe_nxt;
  logic ovf_r, ovf_nxt, unf_r, unf_nxt, pwr_r, pwr_nxt, prd_r, prd_nxt;
  logic [1:0] wix_r, wix_nxt, rix_r, rix_nxt;
  logic [7:0] sout_r, sout_nxt;
  pmp_pins_s pins_r, pins_nxt;
  // Pin synchroniser stages and the filtered view.
  pmp_host_s h1_r, h2_r, h3_r, hf_r, hf_nxt;

  // Apply a polarity bit: level equals the bit when active.
  function automatic logic pol(input logic act, input logic p);
    pol = p ? act : ~act;
  endfunction

  // Phase that follows the address phases.
  function automatic pmp_xfer_e data_ph(input logic s0);
    data_ph = s0 ? PMP_STRB : PMP_SETUP;
  endfunction

  // Opening phase of each byte transfer.
  function automatic pmp_xfer_e first_ph(input logic [1:0] mx, input logic s0);
    first_ph = (mx != `PMP_MUX_SEP) ? PMP_ALO : data_ph(s0);
  endfunction

  // Decoded controls.
  logic on, run, master, sw0, tick, busy, hcs, hwr, hrd, wr_ev, rd_ev, bufd;
  logic [1:0] mux, pmode, widx, ridx;
  logic [3:0] sw;
  assign on = ctrl_r[`PMP_C_ON];
  // Idle halt freezes the sequencer and the host side; software register access goes on.
  assign run = on & ~(CPU_IDLE & ctrl_r[`PMP_C_IDLE]);
  assign mux = ctrl_r[`PMP_C_MUX +: 2];
  assign pmode = mode_r[`PMP_M_MODE +: 2];
  assign master = pmode[1];
  assign sw = mode_r[`PMP_M_STRB +: 4];
  assign sw0 = (sw == 4'h0);
  assign tick = run & (tdiv_r == TCY_M1);
  assign busy = (st_r != PMP_IDLE);
  // Host strobes are judged against the configured polarities.
  assign hcs = pol(hf_r.cs, ctrl_r[`PMP_C_CSP]);
  assign hwr = pol(hf_r.wr, ctrl_r[`PMP_C_WRP]);
  assign hrd = pol(hf_r.rd, ctrl_r[`PMP_C_RDP]);
  assign wr_ev = run & ~master & hcs & hwr & ~pwr_r;
  assign rd_ev = run & ~master & hcs & hrd & ~prd_r;
  assign bufd = (pmode == `PMP_MD_LEG) && (mode_r[`PMP_M_STEP +: 2] == `PMP_STEP_BUF);
  assign widx = (pmode == `PMP_MD_ADR) ? hf_r.pa : (bufd ? wix_r : 2'h0);
  assign ridx = (pmode == `PMP_MD_ADR) ? hf_r.pa : (bufd ? rix_r : 2'h0);

  // Length of a phase in instruction cycles, minus one.
  function automatic logic [3:0] plen(input pmp_xfer_e s);
    logic [3:0] b;
    b = sw0 ? 4'h0 : {2'h0, mode_r[`PMP_M_SETUP +: 2]};
    unique case (s)
      PMP_IDLE: plen = 4'h0;
      PMP_ALO, PMP_AHI, PMP_SETUP: plen = b;
      PMP_STRB: plen = sw;
      PMP_HOLD: plen = sw0 ? 4'h0 : {2'h0, mode_r[`PMP_M_HOLD +: 2]};
    endcase
  endfunction

  // Next state of the filter: a bit moves once stages two and three agree.
  always_comb begin
    hf_nxt = pmp_host_s'((h2_r & ~(h2_r ^ h3_r)) | (hf_r & (h2_r ^ h3_r)));
  end

  // Synchroniser and filter registers; the first stage feeds only the second.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      h1_r <= '0;
      h2_r <= '0;
      h3_r <= '0;
      hf_r <= '0;
    end else begin
      h1_r <= HOST_IN;
      h2_r <= h1_r;
      h3_r <= h2_r;
      hf_r <= hf_nxt;
    end
  end

  // Next values of registers, sequencer, slave buffers and pins.
  always_comb begin
    logic bend;
    logic [7:0] byt;
    bend = 1'b0;
    byt = hi_r ? mdat_r[15:8] : mdat_r[7:0];
    ctrl_nxt = ctrl_r;
    mode_nxt = mode_r;
    addr_nxt = addr_r;
    mdat_nxt = mdat_r;
    rdat_nxt = 16'h0000;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    hi_nxt = hi_r;
    wdir_nxt = wdir_r;
    irq_nxt = 1'b0;
    ib_nxt = ib_r;
    ob_nxt = ob_r;
    ibf_nxt = ibf_r;
    obe_nxt = obe_r;
    ovf_nxt = ovf_r;
    unf_nxt = unf_r;
    wix_nxt = wix_r;
    rix_nxt = rix_r;
    sout_nxt = sout_r;
    pwr_nxt = hcs & hwr;
    prd_nxt = hcs & hrd;
    // The cycle divider only counts while the port runs.
    tdiv_nxt = run ? (tick ? 4'h0 : tdiv_r + 4'h1) : tdiv_r;
    // Master sequencer; counts phases down, one step per instruction cycle.
    if (busy && tick) begin
      if (cnt_r != 4'h0) begin
        cnt_nxt = cnt_r - 4'h1;
      end else begin
        unique case (st_r)
          PMP_IDLE: st_nxt = PMP_IDLE;
          PMP_ALO: st_nxt = (mux == `PMP_MUX_FULL) ? PMP_AHI : data_ph(sw0);
          PMP_AHI: st_nxt = data_ph(sw0);
          PMP_SETUP: st_nxt = PMP_STRB;
          PMP_STRB: begin
            if (sw0) begin
              bend = 1'b1;
            end else begin
              st_nxt = PMP_HOLD;
            end
          end
          PMP_HOLD: bend = 1'b1;
        endcase
      end
    end
    // End of one byte: sample read data, then go on or finish.
    if (bend) begin
      if (!wdir_r) begin
        if (hi_r) begin
          mdat_nxt[15:8] = hf_r.pd;
        end else begin
          mdat_nxt[7:0] = hf_r.pd;
        end
      end
      if (mode_r[`PMP_M_WIDE] && !hi_r) begin
        hi_nxt = 1'b1;
        st_nxt = first_ph(mux, sw0);
      end else begin
        st_nxt = PMP_IDLE;
        irq_nxt = (mode_r[`PMP_M_IRQ +: 2] == `PMP_IRQ_CYC);
        if (mode_r[`PMP_M_STEP +: 2] == `PMP_STEP_INC) begin
          addr_nxt[10:0] = addr_r[10:0] + 11'h1;
        end else if (mode_r[`PMP_M_STEP +: 2] == `PMP_STEP_DEC) begin
          addr_nxt[10:0] = addr_r[10:0] - 11'h1;
        end
      end
    end
    // Host accesses in slave modes; the host sets flags after software clears.
    if (wr_ev) begin
      if (ibf_r[widx]) begin
        ovf_nxt = 1'b1;
      end else begin
        ib_nxt[widx] = hf_r.pd;
      end
      if (bufd) begin
        wix_nxt = wix_r + 2'h1;
      end
    end
    if (rd_ev) begin
      unf_nxt = unf_r | obe_r[ridx];
      sout_nxt = ob_r[ridx];
      if (bufd) begin
        rix_nxt = rix_r + 2'h1;
      end
    end
    if ((wr_ev && widx == 2'h3) || (rd_ev && ridx == 2'h3)) begin
      irq_nxt = (mode_r[`PMP_M_IRQ +: 2] == `PMP_IRQ_BUF)
                && (bufd || pmode == `PMP_MD_ADR);
    end
    // Software writes; a write during a busy transfer to the data register is dropped.
    if (REG_WR) begin
      if (REG_ADDR[3:2] == `PMP_R_BUF) begin
        ob_nxt[REG_ADDR[1:0]] = REG_WDATA[7:0];
        obe_nxt[REG_ADDR[1:0]] = 1'b0;
      end else if (REG_ADDR == `PMP_R_CTRL) begin
        ctrl_nxt = REG_WDATA & `PMP_C_WMASK;
      end else if (REG_ADDR == `PMP_R_MODE) begin
        mode_nxt = REG_WDATA & `PMP_M_WMASK;
      end else if (REG_ADDR == `PMP_R_ADDR) begin
        addr_nxt = REG_WDATA;
      end else if (REG_ADDR == `PMP_R_DATA && master && run && !busy) begin
        mdat_nxt = REG_WDATA;
        wdir_nxt = 1'b1;
        hi_nxt = 1'b0;
        st_nxt = first_ph(mux, sw0);
      end else if (REG_ADDR == `PMP_R_STAT) begin
        // A host event in the same cycle as the clear still sets the flag.
        ovf_nxt = (ovf_r & REG_WDATA[`PMP_S_OVF]) | (wr_ev & ibf_r[widx]);
        unf_nxt = (unf_r & REG_WDATA[`PMP_S_UNF]) | (rd_ev & obe_r[ridx]);
      end
    end
    // Software reads answer one cycle later; a data read starts a master read.
    if (REG_RD) begin
      if (REG_ADDR[3:2] == `PMP_R_BUF) begin
        rdat_nxt = {8'h00, ib_r[REG_ADDR[1:0]]};
        ibf_nxt[REG_ADDR[1:0]] = 1'b0;
      end else if (REG_ADDR == `PMP_R_CTRL) begin
        rdat_nxt = ctrl_r;
      end else if (REG_ADDR == `PMP_R_MODE) begin
        rdat_nxt = {busy, mode_r[14:0]};
      end else if (REG_ADDR == `PMP_R_ADDR) begin
        rdat_nxt = addr_r;
      end else if (REG_ADDR == `PMP_R_DATA) begin
        rdat_nxt = mode_r[`PMP_M_WIDE] ? mdat_r : {8'h00, mdat_r[7:0]};
        if (master && run && !busy) begin
          wdir_nxt = 1'b0;
          hi_nxt = 1'b0;
          st_nxt = first_ph(mux, sw0);
        end
      end else if (REG_ADDR == `PMP_R_STAT) begin
        rdat_nxt = {&ibf_r, ovf_r, 2'h0, ibf_r, &obe_r, unf_r, 2'h0, obe_r};
      end
    end
    // Host data lands after the software side, so a set beats a clear.
    if (wr_ev && !ibf_r[widx]) begin
      ibf_nxt[widx] = 1'b1;
    end
    if (rd_ev) begin
      obe_nxt[ridx] = 1'b1;
    end
    // Turning the port off aborts any transfer at once.
    if (!on) begin
      st_nxt = PMP_IDLE;
    end
    if (st_nxt != st_r) begin
      cnt_nxt = plen(st_nxt);
    end
    // Pin drive, registered one cycle before it reaches the pads.
    pins_nxt = '0;
    pins_nxt.pd_oe_n = 1'b1;
    pins_nxt.pa_oe_n = ~(on & master);
    pins_nxt.cs_oe_n = ~(on & master);
    pins_nxt.rd_oe_n = ~(on & master & ctrl_r[`PMP_C_RD]);
    pins_nxt.wr_oe_n = ~(on & master & ctrl_r[`PMP_C_WR]);
    pins_nxt.be_oe_n = ~(on & master & mode_r[`PMP_M_WIDE] & ctrl_r[`PMP_C_BE]);
    if (mux == `PMP_MUX_SEP) begin
      pins_nxt.pa_out = addr_r[13:0];
    end else begin
      if (mux == `PMP_MUX_PART) begin
        pins_nxt.pa_out[10:8] = addr_r[10:8];
      end
      pins_nxt.pa_out[0] = pol(st_r == PMP_ALO, ctrl_r[`PMP_C_ALP]);
      pins_nxt.pa_out[1] = pol(st_r == PMP_AHI, ctrl_r[`PMP_C_ALP]);
    end
    if (ctrl_r[`PMP_C_CSF +: 2] == `PMP_CSF_CS) begin
      pins_nxt.cs_out = pol(addr_r[`PMP_A_CS], ctrl_r[`PMP_C_CSP]);
    end else begin
      pins_nxt.cs_out = addr_r[`PMP_A_CS];
    end
    if (pmode == 2'h3) begin
      pins_nxt.rd_out = pol(busy & ~wdir_r, ctrl_r[`PMP_C_RDP]);
      pins_nxt.wr_out = pol(st_r == PMP_STRB, ctrl_r[`PMP_C_WRP]);
    end else begin
      pins_nxt.rd_out = pol(st_r == PMP_STRB && !wdir_r, ctrl_r[`PMP_C_RDP]);
      pins_nxt.wr_out = pol(st_r == PMP_STRB && wdir_r, ctrl_r[`PMP_C_WRP]);
    end
    pins_nxt.be_out = pol(busy & hi_r, ctrl_r[`PMP_C_BEP]);
    if (on && master) begin
      if (st_r == PMP_ALO) begin
        pins_nxt.pd_out = addr_r[7:0];
        pins_nxt.pd_oe_n = 1'b0;
      end else if (st_r == PMP_AHI) begin
        pins_nxt.pd_out = addr_r[15:8];
        pins_nxt.pd_oe_n = 1'b0;
      end else if (busy && wdir_r) begin
        pins_nxt.pd_out = byt;
        pins_nxt.pd_oe_n = 1'b0;
      end
    end else if (on) begin
      pins_nxt.pd_out = sout_r;
      pins_nxt.pd_oe_n = ~(hcs & hrd);
    end
  end

  // State registers; sync reset to constants only.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      ctrl_r <= `PMP_RST;
      mode_r <= `PMP_RST;
      addr_r <= `PMP_RST;
      mdat_r <= `PMP_RST;
      rdat_r <= `PMP_RST;
      st_r <= PMP_IDLE;
      cnt_r <= 4'h0;
      tdiv_r <= 4'h0;
      hi_r <= 1'b0;
      wdir_r <= 1'b0;
      irq_r <= 1'b0;
      ib_r <= '{default: 8'h00};
      ob_r <= '{default: 8'h00};
      ibf_r <= 4'h0;
      obe_r <= 4'hf;
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
      pwr_r <= 1'b0;
      prd_r <= 1'b0;
      wix_r <= 2'h0;
      rix_r <= 2'h0;
      sout_r <= 8'h00;
      pins_r <= '{pd_oe_n: 1'b1, pa_oe_n: 1'b1, cs_oe_n: 1'b1, rd_oe_n: 1'b1,
                  wr_oe_n: 1'b1, be_oe_n: 1'b1, default: '0};
    end else begin
      ctrl_r <= ctrl_nxt;
      mode_r <= mode_nxt;
      addr_r <= addr_nxt;
      mdat_r <= mdat_nxt;
      rdat_r <= rdat_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      tdiv_r <= tdiv_nxt;
      hi_r <= hi_nxt;
      wdir_r <= wdir_nxt;
      irq_r <= irq_nxt;
      ib_r <= ib_nxt;
      ob_r <= ob_nxt;
      ibf_r <= ibf_nxt;
      obe_r <= obe_nxt;
      ovf_r <= ovf_nxt;
      unf_r <= unf_nxt;
      pwr_r <= pwr_nxt;
      prd_r <= prd_nxt;
      wix_r <= wix_nxt;
      rix_r <= rix_nxt;
      sout_r <= sout_nxt;
      pins_r <= pins_nxt;
    end
  end

  // Stall holds the processor for the whole transfer.
  assign CPU_STALL = busy && (mode_r[`PMP_M_IRQ +: 2] == `PMP_IRQ_STALL);
  assign PORT_IRQ = irq_r;
  assign REG_RDATA = rdat_r;
  assign PIN_OUT = pins_r;

  // Last phase of the last byte of a master transfer.
  logic bend_q;
  assign bend_q = busy && tick && cnt_r == 4'h0 && st_nxt == PMP_IDLE && on;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  a_off_no_xfer: assert property (!on |=> !busy) else $error("transfer while off");
  a_idle_freeze: assert property (busy && !run && on |=>
    st_r == $past(st_r) && cnt_r == $past(cnt_r)) else $error("ran in idle");
  a_mux_addr: assert property (st_r == PMP_ALO && on && master |=>
    PIN_OUT.pd_out == $past(addr_r[7:0])) else $error("address not on data");
  a_be_pin_off: assert property (!ctrl_r[`PMP_C_BE] |=> PIN_OUT.be_oe_n)
    else $error("byte enable driven");
  a_cs_level: assert property (ctrl_r[`PMP_C_CSF +: 2] == `PMP_CSF_CS |=>
    PIN_OUT.cs_out == ($past(addr_r[14]) == $past(ctrl_r[3]))) else $error("chip select level");
  a_short_op: assert property (st_r == PMP_STRB && sw0 && tick |=> st_r != PMP_HOLD)
    else $error("hold not skipped");
  a_order_seq: assert property (st_r == PMP_SETUP |=>
    st_r inside {PMP_SETUP, PMP_STRB, PMP_IDLE}) else $error("phase order");
  a_ovf_set: assert property (wr_ev && ibf_r[widx] |=> ovf_r)
    else $error("overflow missed");
  a_unf_set: assert property (rd_ev && obe_r[ridx] |=> unf_r)
    else $error("underflow missed");
  a_step_inc: assert property (bend_q && mode_r[12:11] == 2'h1 && !REG_WR |=>
    addr_r[10:0] == $past(addr_r[10:0]) + 11'h1) else $error("no increment");

  c_write: cover property (REG_WR && REG_ADDR == `PMP_R_DATA && master ##[1:200] !busy);
  c_wide: cover property (hi_r && busy && mode_r[`PMP_M_WIDE]);
  c_host_wr: cover property (wr_ev && widx == 2'h3);
  c_ovf: cover property (!ovf_r ##1 ovf_r);
endmodule

// [verif/pmp_ext_mem.sv]
// Far-side model: a byte memory for master cycles and a host for slave cycles.
module pmp_ext_mem
  import pmp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic STRB_HI,
  input wire pmp_pkg::pmp_pins_s PIN_OUT,
  output pmp_pkg::pmp_host_s HOST_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256]; // Memory cells, indexed by the low address pins.
  logic [7:0] last_r = 8'h00; // Last bus level, used to scramble a released bus.
  logic [3:0] hold_r = 4'h0; // Read data hold count after the strobe ends.
  logic h_cs = 1'b0; // Host strobe requests, active when set.
  logic h_wr = 1'b0;
  logic h_rd = 1'b0;
  logic h_drv = 1'b0; // Host drives the data pins.
  logic [1:0] h_pa = 2'h0;
  logic [7:0] h_pd = 8'h00;
  logic wr_on;
  logic rd_on;
  assign wr_on = !PIN_OUT.wr_oe_n && (PIN_OUT.wr_out == STRB_HI);
  assign rd_on = !PIN_OUT.rd_oe_n && (PIN_OUT.rd_out == STRB_HI);
  // Write data is taken every strobe cycle; a real part holds read data only briefly.
  always @(posedge CLOCK) begin
    last_r <= HOST_IN.pd;
    hold_r <= rd_on ? 4'h8 : (hold_r != 4'h0 ? hold_r - 4'h1 : 4'h0);
    if (wr_on) begin
      mem[PIN_OUT.pa_out[7:0]] <= PIN_OUT.pd_out;
    end
  end
  // Wire levels; an undriven bus toggles so a stale value never looks valid.
  always_comb begin
    HOST_IN.cs = h_cs ^ !STRB_HI;
    HOST_IN.wr = h_wr ^ !STRB_HI;
    HOST_IN.rd = h_rd ^ !STRB_HI;
    HOST_IN.pa = h_pa;
    if (!PIN_OUT.pd_oe_n) begin
      HOST_IN.pd = PIN_OUT.pd_out;
    end else if (h_drv) begin
      HOST_IN.pd = h_pd;
    end else if (rd_on || hold_r != 4'h0) begin
      HOST_IN.pd = mem[PIN_OUT.pa_out[7:0]];
    end else begin
      HOST_IN.pd = ~last_r;
    end
  end
  // One host access; strobes are held long enough to pass the input filter.
  task automatic host_cycle(input logic w, input logic [1:0] a, input logic [7:0] d,
                            output logic [7:0] q);
    @(posedge CLOCK);
    h_cs <= 1'b1;
    h_wr <= w;
    h_rd <= !w;
    h_pa <= a;
    h_pd <= d;
    h_drv <= w;
    repeat (8) @(posedge CLOCK);
    @(negedge CLOCK);
    q = HOST_IN.pd;
    @(posedge CLOCK);
    h_cs <= 1'b0;
    h_wr <= 1'b0;
    h_rd <= 1'b0;
    h_drv <= 1'b0;
    repeat (6) @(posedge CLOCK);
  endtask
endmodule

// [verif/pmp_port_tb_top.sv]
// Self-checking bench for the parallel port.
module pmp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pmp_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cpu_idle = 1'b0;
  logic [15:0] reg_rdata;
  logic cpu_stall;
  logic port_irq;
  pmp_host_s host_in;
  pmp_pins_s pin_out;
  int err_count = 0;
  int comparisons = 0;
  logic [15:0] q; // Last register read.
  logic [7:0] hq; // Last byte seen by the host.
  logic [1:0] lat; // Latch strobes in the first cycle of a transfer.
  int lead;
  int width;
  int n;
  int m;
  pmp_port dut (.CLOCK(clock), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CPU_IDLE(cpu_idle),
    .CPU_STALL(cpu_stall), .PORT_IRQ(port_irq), .HOST_IN(host_in), .PIN_OUT(pin_out));
  pmp_ext_mem u_mem (.CLOCK(clock), .STRB_HI(1'b1), .PIN_OUT(pin_out), .HOST_IN(host_in));
  // Clock at 4 ns period.
  always #2 clock = ~clock;
  // Register write, one strobe cycle.
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Register read; data stands only in the cycle after the strobe.
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic stb(input logic r);
    return r ? pin_out.rd_out : pin_out.wr_out;
  endfunction
  // Edges until the strobe pin goes active, then how long it stays active.
  task automatic meas(input logic r);
    lead = 0;
    width = 0;
    do begin
      @(posedge clock);
      #1;
      lead++;
      if (lead == 1) lat = pin_out.pa_out[1:0];
    end while (stb(r) !== 1'b1 && lead < 40);
    while (stb(r) === 1'b1 && width < 40) begin
      @(posedge clock);
      #1;
      width++;
    end
    repeat (8) @(posedge clock);
  endtask
  // Ends the run; the only place with a verdict.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Reset values, plus an unmapped index that reads zero.
  task automatic t_reset();
    rd_reg(4'h0);
    chk(q, 16'h0000);
    rd_reg(4'h1);
    chk(q, 16'h0000);
    rd_reg(4'h2);
    chk(q, 16'h0000);
    rd_reg(4'h4);
    chk(q, 16'h008f);
    rd_reg(4'h7);
    chk(q, 16'h0000);
    $display("test reset done");
  endtask
  // Port off and idle halt block transfers; idle alone does not.
  task automatic t_block();
    wr_reg(4'h1, 16'h0200);
    wr_reg(4'h0, 16'h0303);
    wr_reg(4'h3, 16'h0011);
    meas(0);
    chk_n(width, 0);
    wr_reg(4'h0, 16'ha303);
    cpu_idle <= 1'b1;
    wr_reg(4'h3, 16'h0022);
    meas(0);
    chk_n(width, 0);
    wr_reg(4'h0, 16'h8303);
    wr_reg(4'h3, 16'h0033);
    meas(0);
    chk_n(width, 1);
    // Halting in mid-transfer freezes busy until the idle level drops.
    wr_reg(4'h1, 16'h023f);
    wr_reg(4'h3, 16'h0044);
    wr_reg(4'h0, 16'ha303);
    repeat (40) @(posedge clock);
    rd_reg(4'h1);
    chk(q, 16'h823f);
    cpu_idle <= 1'b0;
    repeat (30) @(posedge clock);
    $display("test block done");
  endtask
  // Wait fields and strobe modes: phase lengths seen on the write strobe.
  task automatic t_waits();
    logic [15:0] md [5] = '{16'h024d, 16'h02c4, 16'h023f, 16'h02c3, 16'h0300};
    int le [5] = '{3, 5, 2, 1, 1};
    int wi [5] = '{4, 2, 16, 1, 1};
    for (int i = 0; i < 5; i++) begin
      wr_reg(4'h1, md[i]);
      wr_reg(4'h3, 16'h0044);
      meas(0);
      chk_n(lead, le[i]);
      chk_n(width, wi[i]);
    end
    $display("test waits done");
  endtask
  // Multiplexed address phases come first, with latch strobes at set polarity.
  task automatic t_mux();
    logic [15:0] ct [3] = '{16'h8b23, 16'h9323, 16'h8b03};
    int le [3] = '{2, 3, 2};
    logic [1:0] lx [3] = '{2'b01, 2'b01, 2'b10};
    wr_reg(4'h1, 16'h0200);
    for (int i = 0; i < 3; i++) begin
      wr_reg(4'h0, ct[i]);
      wr_reg(4'h3, 16'h0055);
      meas(0);
      chk_n(lead, le[i]);
      chk({14'h0, lat}, {14'h0, lx[i]});
    end
    wr_reg(4'h0, 16'h8303);
    $display("test mux done");
  endtask
  // Writes land in memory and the address steps up or down.
  task automatic t_step();
    wr_reg(4'h2, 16'h0012);
    wr_reg(4'h1, 16'h0a00);
    wr_reg(4'h3, 16'h00a5);
    meas(0);
    chk({8'h00, u_mem.mem[8'h12]}, 16'h00a5);
    rd_reg(4'h2);
    chk(q, 16'h0013);
    wr_reg(4'h1, 16'h1200);
    wr_reg(4'h3, 16'h003c);
    meas(0);
    chk({8'h00, u_mem.mem[8'h13]}, 16'h003c);
    rd_reg(4'h2);
    chk(q, 16'h0012);
    $display("test step done");
  endtask
  // Busy, stall and end-of-cycle interrupt.
  task automatic t_busy();
    wr_reg(4'h1, 16'h423f);
    wr_reg(4'h3, 16'h0066);
    #1;
    chk({15'h0, cpu_stall}, 16'h0001);
    rd_reg(4'h1);
    chk(q, 16'hc23f);
    repeat (40) @(posedge clock);
    rd_reg(4'h1);
    chk(q, 16'h423f);
    chk({15'h0, cpu_stall}, 16'h0000);
    wr_reg(4'h1, 16'h223f);
    wr_reg(4'h3, 16'h0077);
    n = 0;
    repeat (40) begin
      @(posedge clock);
      #1;
      n += (port_irq === 1'b1);
    end
    chk_n(n, 1);
    $display("test busy done");
  endtask
  // Read from memory, then a wide write with and without the byte enable pin.
  task automatic t_data();
    u_mem.mem[8'h40] = 8'h77;
    wr_reg(4'h2, 16'h0040);
    wr_reg(4'h1, 16'h020f);
    rd_reg(4'h3);
    repeat (30) @(posedge clock);
    rd_reg(4'h3);
    chk({8'h00, q[7:0]}, 16'h0077);
    repeat (30) @(posedge clock);
    for (int i = 0; i < 2; i++) begin
      wr_reg(4'h0, i == 0 ? 16'h8707 : 16'h8303);
      wr_reg(4'h1, 16'h0600);
      wr_reg(4'h3, 16'hbeef);
      n = 0;
      m = 0;
      repeat (20) begin
        @(posedge clock);
        #1;
        n += (pin_out.wr_out === 1'b1);
        m += (pin_out.be_oe_n === 1'b0 && pin_out.be_out === 1'b1);
      end
      chk_n(n, 2);
      chk_n(m, i == 0 ? 1 : 0);
    end
    chk({8'h00, u_mem.mem[8'h40]}, 16'h00be);
    $display("test data done");
  endtask
  // Chip select level from the select bit, polarity, and address use.
  task automatic t_cs();
    logic [15:0] ct [4] = '{16'h838b, 16'h8383, 16'h8383, 16'h8303};
    logic [15:0] ad [4] = '{16'h4000, 16'h4000, 16'h0000, 16'h4000};
    logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      wr_reg(4'h0, ct[i]);
      wr_reg(4'h2, ad[i]);
      repeat (3) @(posedge clock);
      #1;
      chk({14'h0, pin_out.cs_oe_n, pin_out.cs_out}, {14'h0, 1'b0, ex[i]});
    end
    $display("test cs done");
  endtask
  // Legacy slave: host writes, overflow, underflow, software clear, host read.
  task automatic t_slave();
    wr_reg(4'h0, 16'h830b);
    wr_reg(4'h1, 16'h0000);
    u_mem.host_cycle(1'b1, 2'h0, 8'h5a, hq);
    rd_reg(4'h4);
    chk(q & 16'h4100, 16'h0100);
    u_mem.host_cycle(1'b1, 2'h0, 8'h6b, hq);
    rd_reg(4'h4);
    chk(q & 16'h4000, 16'h4000);
    rd_reg(4'h8);
    chk({8'h00, q[7:0]}, 16'h005a);
    u_mem.host_cycle(1'b0, 2'h0, 8'h00, hq);
    rd_reg(4'h4);
    chk(q & 16'h0040, 16'h0040);
    wr_reg(4'h4, 16'h0000);
    rd_reg(4'h4);
    chk(q & 16'h4040, 16'h0000);
    wr_reg(4'h8, 16'h0033);
    u_mem.host_cycle(1'b0, 2'h0, 8'h00, hq);
    chk({8'h00, hq}, 16'h0033);
    // Addressable slave with buffer 3 interrupts, then the legacy buffer walk.
    wr_reg(4'h1, 16'h6100);
    n = 0;
    fork
      u_mem.host_cycle(1'b1, 2'h3, 8'h9c, hq);
      repeat (16) begin
        @(posedge clock);
        #1;
        n += (port_irq === 1'b1);
      end
    join
    chk_n(n, 1);
    rd_reg(4'hb);
    chk(q, 16'h009c);
    wr_reg(4'h1, 16'h1800);
    u_mem.host_cycle(1'b1, 2'h0, 8'h11, hq);
    u_mem.host_cycle(1'b1, 2'h0, 8'h22, hq);
    rd_reg(4'h9);
    chk(q, 16'h0022);
    $display("test slave done");
  endtask
  // Main sequence.
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_block();
    t_waits();
    t_mux();
    t_step();
    t_busy();
    t_data();
    t_cs();
    t_slave();
    tally_and_finish();
  end
  // Watchdog, well beyond the under one thousand cycles the tests need.
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
endmodule
